// ### hdl/xdt_decoder.v
// Instruction tail decoder: takes opcode bytes from fetch, gathers the
// operand address byte, displacement and immediate, forms the
// effective address and hands a decoded record to execution.
// Assumes fetch and register file share sys_clk; no synchronisers.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "xdt_defines.vh"

module xdt_decoder (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  output reg         byte_ready_q,
  input  wire [15:0] bx_val,
  input  wire [15:0] bp_val,
  input  wire [15:0] si_val,
  input  wire [15:0] di_val,
  input  wire [7:0]  al_val,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  output reg         dec_valid_q,
  output reg  [3:0]  dec_op_q,
  output reg         dec_word_q,
  output reg  [1:0]  dec_mode_q,
  output reg  [2:0]  dec_aux_q,
  output reg         dec_ext_q,
  output reg  [2:0]  dec_reg_q,
  output reg  [2:0]  dec_rm_q,
  output reg         dec_mem_q,
  output reg  [15:0] dec_disp_q,
  output reg  [15:0] dec_imm_q,
  output reg  [15:0] dec_ea_q,
  output reg  [1:0]  dec_seg_q,
  output reg  [15:0] dec_step_q,
  output reg         dec_wb_q,
  output reg  [7:0]  dec_clk_q,
  output reg         dec_clk_n_q,
  output reg  [8:0]  flag_res_q,
  output reg  [8:0]  flag_clr_q,
  output reg  [8:0]  flag_set_q,
  output reg  [8:0]  flag_undef_q,
  output reg         dec_illegal_q,
  output reg         irq_en_q,
  output reg         dir_q
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_MRM  = 3'h1;
  localparam [2:0] ST_DLO  = 3'h2;
  localparam [2:0] ST_DHI  = 3'h3;
  localparam [2:0] ST_ILO  = 3'h4;
  localparam [2:0] ST_IHI  = 3'h5;
  localparam [2:0] ST_EMIT = 3'h6;

  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [7:0]  opc_q;
  reg  [7:0]  mrm_q;
  reg  [15:0] disp_q;
  reg  [15:0] imm_q;
  reg  [1:0]  disp_n_q;
  reg  [1:0]  imm_n_q;
  reg  [1:0]  seg_q;
  reg         ovr_q;
  reg  [1:0]  ctrl_q;
  reg         ien_pend_q;
  reg  [15:0] count_q;
  reg  [15:0] last_q;

  // ----------------------------------------------------------------
  // Operand address byte fields
  // ----------------------------------------------------------------
  wire [1:0] f_mod = mrm_q[`XDT_MOD_HI:`XDT_MOD_LO];
  wire [2:0] f_aux = mrm_q[`XDT_AUX_HI:`XDT_AUX_LO];
  wire [2:0] f_rm  = mrm_q[`XDT_RM_HI:`XDT_RM_LO];
  wire [1:0] b_mod = byte_data[`XDT_MOD_HI:`XDT_MOD_LO];
  wire [2:0] b_aux = byte_data[`XDT_AUX_HI:`XDT_AUX_LO];
  wire [2:0] b_rm  = byte_data[`XDT_RM_HI:`XDT_RM_LO];
  wire       take  = byte_valid && byte_ready_q && ctrl_q[`XDT_CTRL_EN];
  wire       narrow = ctrl_q[`XDT_CTRL_NARROW];
  wire       is_pfx = (byte_data[7:5] == 3'h1) && (byte_data[2:0] == 3'h6);

  // Opcode carries an operand address byte
  reg        has_mrm;
  reg [1:0]  acc_imm_n;
  always @*
  begin
    has_mrm   = 1'b0;
    acc_imm_n = 2'h0;
    case (byte_data)
      8'h18, 8'h19, 8'h1a, 8'h1b, 8'h28, 8'h29, 8'h2a, 8'h2b,
      8'h30, 8'h31, 8'h32, 8'h33, 8'h80, 8'h81, 8'h83, 8'h84,
      8'h85, 8'h86, 8'h87, 8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2,
      8'hd3, 8'hf6, 8'hf7: has_mrm = 1'b1;
      8'h1c, 8'h2c, 8'h34, 8'ha8: acc_imm_n = 2'h1;
      8'h1d, 8'h2d, 8'h35, 8'ha9: acc_imm_n = 2'h2;
      default: has_mrm = 1'b0;
    endcase
  end

  // Immediate bytes that follow the operand address byte
  reg [1:0] mrm_imm_n;
  always @*
  begin
    case (opc_q)
      8'h80, 8'h83, 8'hc0, 8'hc1: mrm_imm_n = 2'h1;
      8'h81:   mrm_imm_n = 2'h2;
      8'hf6:   mrm_imm_n = (b_aux == 3'h0) ? 2'h1 : 2'h0;
      8'hf7:   mrm_imm_n = (b_aux == 3'h0) ? 2'h2 : 2'h0;
      default: mrm_imm_n = 2'h0;
    endcase
  end

  // Displacement size from the mode field
  reg [1:0] b_disp_n;
  always @*
  begin
    case (b_mod)
      2'h0:    b_disp_n = (b_rm == 3'h6) ? 2'h2 : 2'h0;
      2'h1:    b_disp_n = 2'h1;
      2'h2:    b_disp_n = 2'h2;
      default: b_disp_n = 2'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Byte gathering state machine
  // ----------------------------------------------------------------
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (take && !is_pfx)
          st_d = has_mrm ? ST_MRM : (acc_imm_n != 2'h0) ? ST_ILO : ST_EMIT;
      ST_MRM:
        if (take)
          st_d = (b_mod != 2'h3 && b_disp_n != 2'h0) ? ST_DLO :
                 (mrm_imm_n != 2'h0) ? ST_ILO : ST_EMIT;
      ST_DLO:
        if (take)
          st_d = (disp_n_q == 2'h2) ? ST_DHI : (imm_n_q != 2'h0) ? ST_ILO : ST_EMIT;
      ST_DHI:
        if (take)
          st_d = (imm_n_q != 2'h0) ? ST_ILO : ST_EMIT;
      ST_ILO:
        if (take)
          st_d = (imm_n_q == 2'h2) ? ST_IHI : ST_EMIT;
      ST_IHI:
        if (take)
          st_d = ST_EMIT;
      ST_EMIT: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Instruction decode from the gathered bytes
  // ----------------------------------------------------------------
  reg [3:0] d_op;
  reg       d_word;
  reg       d_ext;
  reg       d_mem;
  reg [7:0] d_clk_r;
  reg [7:0] d_clk_m;
  reg       d_n;
  wire      acc_form = (opc_q == 8'h1c) || (opc_q == 8'h1d) || (opc_q == 8'h2c) ||
                       (opc_q == 8'h2d) || (opc_q == 8'h34) || (opc_q == 8'h35) ||
                       (opc_q == 8'ha8) || (opc_q == 8'ha9);
  wire      has_m = (f_mod != 2'h3);
  always @*
  begin
    d_op    = `XDT_OP_NONE;
    d_word  = opc_q[0];
    d_ext   = 1'b0;
    d_mem   = 1'b0;
    d_clk_r = `XDT_CLK_RR;
    d_clk_m = `XDT_CLK_RM;
    d_n     = 1'b0;
    case (opc_q)
      8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3:
      begin
        d_ext   = 1'b1;
        d_mem   = has_m;
        d_op    = (f_aux == 3'h7) ? `XDT_OP_ASHR :
                  (f_aux == 3'h5) ? `XDT_OP_LSHR : `XDT_OP_NONE;
        d_n     = !(opc_q == 8'hd0 || opc_q == 8'hd1);
        d_clk_r = d_n ? `XDT_CLK_SHN_R : `XDT_CLK_SH1_R;
        d_clk_m = d_n ? `XDT_CLK_SHN_M : `XDT_CLK_SH1_M;
      end
      8'h80, 8'h81, 8'h83:
      begin
        d_ext   = 1'b1;
        d_mem   = has_m;
        d_op    = (f_aux == 3'h3) ? `XDT_OP_SUBB :
                  (f_aux == 3'h5) ? `XDT_OP_SUB :
                  (f_aux == 3'h6) ? `XDT_OP_XOR : `XDT_OP_NONE;
        d_clk_r = `XDT_CLK_IMM_R;
        d_clk_m = `XDT_CLK_IMM_M;
      end
      8'hf6, 8'hf7:
      begin
        d_ext   = 1'b1;
        d_mem   = has_m;
        d_op    = (f_aux == 3'h0) ? `XDT_OP_TEST : `XDT_OP_NONE;
        d_clk_r = `XDT_CLK_IMM_R;
      end
      8'h18, 8'h19, 8'h1a, 8'h1b:
      begin
        d_op  = `XDT_OP_SUBB;
        d_mem = has_m;
      end
      8'h28, 8'h29, 8'h2a, 8'h2b:
      begin
        d_op  = `XDT_OP_SUB;
        d_mem = has_m;
      end
      8'h30, 8'h31, 8'h32, 8'h33:
      begin
        d_op  = `XDT_OP_XOR;
        d_mem = has_m;
      end
      8'h84, 8'h85:
      begin
        d_op  = `XDT_OP_TEST;
        d_mem = has_m;
      end
      8'h86, 8'h87:
      begin
        d_op    = `XDT_OP_SWAP;
        d_mem   = has_m;
        d_clk_r = `XDT_CLK_SWP_R;
        d_clk_m = `XDT_CLK_SWP_M;
      end
      8'h1c, 8'h1d: d_op = `XDT_OP_SUBB;
      8'h2c, 8'h2d: d_op = `XDT_OP_SUB;
      8'h34, 8'h35: d_op = `XDT_OP_XOR;
      8'ha8, 8'ha9: d_op = `XDT_OP_TEST;
      8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97:
      begin
        d_op    = `XDT_OP_SWAP;
        d_word  = 1'b1;
        d_clk_r = `XDT_CLK_SWPAX;
      end
      8'hae, 8'haf:
      begin
        d_op    = `XDT_OP_SCAN;
        d_mem   = 1'b1;
        d_clk_m = narrow ? `XDT_CLK_SCAN_N : `XDT_CLK_SCAN;
      end
      8'haa, 8'hab:
      begin
        d_op    = `XDT_OP_STORE;
        d_mem   = 1'b1;
        d_clk_m = `XDT_CLK_STORE;
      end
      8'hd7:
      begin
        d_op    = `XDT_OP_XLT;
        d_word  = 1'b0;
        d_mem   = 1'b1;
        d_clk_m = narrow ? `XDT_CLK_XLT_N : `XDT_CLK_XLT;
      end
      8'hf9: d_op = `XDT_OP_SETC;
      8'hfd: d_op = `XDT_OP_SETD;
      8'hfb: d_op = `XDT_OP_SETI;
      default: d_op = `XDT_OP_NONE;
    endcase
    // Accumulator immediate forms cost 3 for bytes, 4 for words
    if (acc_form)
      d_clk_r = d_word ? `XDT_CLK_AI16 : `XDT_CLK_AI8;
    if (d_op == `XDT_OP_SETC || d_op == `XDT_OP_SETD || d_op == `XDT_OP_SETI)
      d_clk_r = `XDT_CLK_FLAG;
  end

  wire str_op = (d_op == `XDT_OP_SCAN) || (d_op == `XDT_OP_STORE);
  wire shf_op = (d_op == `XDT_OP_ASHR) || (d_op == `XDT_OP_LSHR);

  // Clock count, register or memory column, narrow bus adds for memory words except shifts and scans
  reg [7:0] d_clk;
  always @*
  begin
    d_clk = d_mem ? d_clk_m : d_clk_r;
    if (narrow && d_mem && d_word && !shf_op && d_op != `XDT_OP_SCAN)
      d_clk = d_clk_m + `XDT_CLK_NARROW;
  end

  // ----------------------------------------------------------------
  // Effective address and segment
  // ----------------------------------------------------------------
  reg [15:0] ea_base;
  reg [15:0] ea_idx;
  reg        bp_based;
  wire       direct = (f_mod == 2'h0) && (f_rm == 3'h6);
  always @*
  begin
    ea_idx   = 16'h0000;
    bp_based = 1'b0;
    case (f_rm)
      3'h0: begin ea_base = bx_val; ea_idx = si_val; end
      3'h1: begin ea_base = bx_val; ea_idx = di_val; end
      3'h2: begin ea_base = bp_val; ea_idx = si_val; bp_based = 1'b1; end
      3'h3: begin ea_base = bp_val; ea_idx = di_val; bp_based = 1'b1; end
      3'h4: ea_base = si_val;
      3'h5: ea_base = di_val;
      3'h6: begin ea_base = bp_val; bp_based = 1'b1; end
      default: ea_base = bx_val;
    endcase
  end

  reg [15:0] d_ea;
  reg [1:0]  d_seg;
  always @*
  begin
    d_ea  = direct ? disp_q : ea_base + ea_idx + disp_q;
    d_seg = (bp_based && !direct) ? 2'h2 : 2'h3;
    if (str_op)
    begin
      d_ea  = di_val;
      d_seg = 2'h0;
    end
    else if (d_op == `XDT_OP_XLT)
    begin
      d_ea  = bx_val + {8'h00, al_val};
      d_seg = ovr_q ? seg_q : 2'h3;
    end
    else if (ovr_q)
      d_seg = seg_q;
  end

  // Flag effects per operation
  reg [8:0] m_res;
  reg [8:0] m_clr;
  reg [8:0] m_set;
  reg [8:0] m_und;
  localparam [8:0] F_ARITH = 9'h11f;
  localparam [8:0] F_SZP   = 9'h01a;
  localparam [8:0] F_OA    = 9'h104;
  localparam [8:0] F_OC    = 9'h101;
  always @*
  begin
    m_res = 9'h000;
    m_clr = 9'h000;
    m_set = 9'h000;
    m_und = 9'h000;
    case (d_op)
      `XDT_OP_ASHR: begin m_res = F_SZP | 9'h001; m_und = F_OA; end
      `XDT_OP_LSHR: begin m_res = F_SZP; m_clr = 9'h001; m_und = F_OA; end
      `XDT_OP_SUBB, `XDT_OP_SUB, `XDT_OP_SCAN: m_res = F_ARITH;
      `XDT_OP_TEST, `XDT_OP_XOR:
      begin
        m_res = F_SZP;
        m_clr = F_OC;
        m_und = 9'h004;
      end
      `XDT_OP_SETC: m_set[`XDT_F_C] = 1'b1;
      `XDT_OP_SETD: m_set[`XDT_F_D] = 1'b1;
      `XDT_OP_SETI: m_set[`XDT_F_I] = 1'b1;
      default: m_res = 9'h000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequential datapath
  // ----------------------------------------------------------------
  wire emit = (st_q == ST_EMIT);
  wire wr_st = reg_wr && (reg_addr == `XDT_ADDR_STAT);
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q         <= ST_IDLE;
      byte_ready_q <= 1'b0;
      opc_q        <= 8'h00;
      mrm_q        <= 8'h00;
      disp_q       <= 16'h0000;
      imm_q        <= 16'h0000;
      disp_n_q     <= 2'h0;
      imm_n_q      <= 2'h0;
      seg_q        <= 2'h0;
      ovr_q        <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;
      byte_ready_q <= (st_d != ST_EMIT);
      if (take)
        case (st_q)
          ST_IDLE:
            if (is_pfx)
            begin
              ovr_q <= 1'b1;
              seg_q <= byte_data[`XDT_SR_HI:`XDT_SR_LO];
            end
            else
            begin
              opc_q   <= byte_data;
              mrm_q   <= 8'hc0 | byte_data; // Register-form default
              disp_q  <= 16'h0000;
              imm_q   <= 16'h0000;
              imm_n_q <= acc_imm_n;
            end
          ST_MRM:
          begin
            mrm_q    <= byte_data;
            disp_n_q <= b_disp_n;
            imm_n_q  <= mrm_imm_n;
          end
          ST_DLO: disp_q <= {{8{byte_data[7]}}, byte_data};
          ST_DHI: disp_q[15:8] <= byte_data;
          ST_ILO: imm_q <= {{8{byte_data[7]}}, byte_data};
          ST_IHI: imm_q[15:8] <= byte_data;
          default: opc_q <= opc_q;
        endcase
      if (emit)
        ovr_q <= 1'b0;
    end
  end

  // Decoded record, held until the next instruction
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      dec_valid_q   <= 1'b0;
      dec_op_q      <= `XDT_OP_NONE;
      dec_word_q    <= 1'b0;
      dec_mode_q    <= 2'h0;
      dec_aux_q     <= 3'h0;
      dec_ext_q     <= 1'b0;
      dec_reg_q     <= 3'h0;
      dec_rm_q      <= 3'h0;
      dec_mem_q     <= 1'b0;
      dec_disp_q    <= 16'h0000;
      dec_imm_q     <= 16'h0000;
      dec_ea_q      <= 16'h0000;
      dec_seg_q     <= 2'h0;
      dec_step_q    <= 16'h0000;
      dec_wb_q      <= 1'b0;
      dec_clk_q     <= 8'h00;
      dec_clk_n_q   <= 1'b0;
      flag_res_q    <= 9'h000;
      flag_clr_q    <= 9'h000;
      flag_set_q    <= 9'h000;
      flag_undef_q  <= 9'h000;
    end
    else
    begin
      dec_valid_q <= emit;
      if (emit)
      begin
        dec_op_q     <= d_op;
        dec_word_q   <= d_word;
        dec_mode_q   <= f_mod;
        dec_aux_q    <= f_aux;
        dec_ext_q    <= d_ext;
        dec_reg_q    <= (opc_q[7:3] == 5'h12) ? opc_q[2:0] : f_aux;
        dec_rm_q     <= f_rm;
        dec_mem_q    <= d_mem;
        dec_disp_q   <= disp_q;
        dec_imm_q    <= imm_q;
        dec_ea_q     <= d_ea;
        dec_seg_q    <= d_seg;
        dec_step_q   <= !str_op ? 16'h0000 :
                        dir_q ? (d_word ? 16'hfffe : 16'hffff) :
                        (d_word ? 16'h0002 : 16'h0001);
        dec_wb_q     <= (d_op != `XDT_OP_TEST) && (d_op != `XDT_OP_SCAN) &&
                        (d_op != `XDT_OP_NONE);
        dec_clk_q    <= d_clk;
        dec_clk_n_q  <= d_n;
        flag_res_q   <= m_res;
        flag_clr_q   <= m_clr;
        flag_set_q   <= m_set;
        flag_undef_q <= m_und;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode state, status and register port
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_q        <= `XDT_CTRL_RST;
      ien_pend_q    <= 1'b0;
      irq_en_q      <= 1'b0;
      dir_q         <= 1'b0;
      dec_illegal_q <= 1'b0;
      count_q       <= 16'h0000;
      last_q        <= 16'h0000;
      reg_rdata_q   <= 32'h00000000;
    end
    else
    begin
      if (reg_wr && reg_addr == `XDT_ADDR_CTRL)
        ctrl_q <= reg_wdata[1:0];
      // Write one clears; a hardware set in the same cycle wins
      if (wr_st && reg_wdata[`XDT_STAT_IRQ])
        irq_en_q <= 1'b0;
      if (wr_st && reg_wdata[`XDT_STAT_DIR])
        dir_q <= 1'b0;
      if (wr_st && reg_wdata[`XDT_STAT_ILL])
        dec_illegal_q <= 1'b0;
      if (emit)
      begin
        count_q <= count_q + 16'h0001;
        last_q  <= {opc_q, mrm_q};
        if (d_op == `XDT_OP_NONE)
          dec_illegal_q <= 1'b1;
        if (d_op == `XDT_OP_SETD)
          dir_q <= 1'b1;
        if (d_op == `XDT_OP_SETI)
          ien_pend_q <= 1'b1;
        else if (ien_pend_q)
        begin
          ien_pend_q <= 1'b0;
          irq_en_q   <= 1'b1;
        end
      end
      reg_rdata_q <= 32'h00000000;
      if (reg_rd)
        case (reg_addr)
          `XDT_ADDR_CTRL:  reg_rdata_q <= {30'h0, ctrl_q};
          `XDT_ADDR_STAT:  reg_rdata_q <= {29'h0, dec_illegal_q, dir_q, irq_en_q};
          `XDT_ADDR_COUNT: reg_rdata_q <= {16'h0000, count_q};
          `XDT_ADDR_LAST:  reg_rdata_q <= {16'h0000, last_q};
          default:         reg_rdata_q <= 32'h00000000;
        endcase
    end
  end

endmodule // xdt_decoder

// ### hdl/xdt_defines.vh
// Constants for the instruction tail decoder: register map, fields,
// operation classes, flag positions and clock counts.
// Assumes inclusion by bare name from the decoder module.
`ifndef XDT_DEFINES_VH
`define XDT_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define XDT_ADDR_CTRL   8'h00
`define XDT_ADDR_STAT   8'h04
`define XDT_ADDR_COUNT  8'h08
`define XDT_ADDR_LAST   8'h0c
`define XDT_CTRL_EN     0
`define XDT_CTRL_NARROW 1
`define XDT_CTRL_RST    2'h1
`define XDT_STAT_IRQ    0
`define XDT_STAT_DIR    1
`define XDT_STAT_ILL    2

// ----------------------------------------------------------------
// Operand address byte fields
// ----------------------------------------------------------------
`define XDT_MOD_HI      7
`define XDT_MOD_LO      6
`define XDT_AUX_HI      5
`define XDT_AUX_LO      3
`define XDT_RM_HI       2
`define XDT_RM_LO       0
`define XDT_SR_HI       4
`define XDT_SR_LO       3

// ----------------------------------------------------------------
// Operation classes
// ----------------------------------------------------------------
`define XDT_OP_NONE     4'h0
`define XDT_OP_ASHR     4'h1
`define XDT_OP_LSHR     4'h2
`define XDT_OP_SUBB     4'h3
`define XDT_OP_SUB      4'h4
`define XDT_OP_SCAN     4'h5
`define XDT_OP_SETC     4'h6
`define XDT_OP_SETD     4'h7
`define XDT_OP_SETI     4'h8
`define XDT_OP_STORE    4'h9
`define XDT_OP_TEST     4'ha
`define XDT_OP_SWAP     4'hb
`define XDT_OP_XLT      4'hc
`define XDT_OP_XOR      4'hd

// ----------------------------------------------------------------
// Flag positions: O D I T S Z A P C
// ----------------------------------------------------------------
`define XDT_F_O         8
`define XDT_F_D         7
`define XDT_F_I         6
`define XDT_F_S         4
`define XDT_F_Z         3
`define XDT_F_A         2
`define XDT_F_P         1
`define XDT_F_C         0

// ----------------------------------------------------------------
// Clock counts
// ----------------------------------------------------------------
`define XDT_CLK_SH1_R   8'h02
`define XDT_CLK_SH1_M   8'h0f
`define XDT_CLK_SHN_R   8'h05
`define XDT_CLK_SHN_M   8'h11
`define XDT_CLK_AI8     8'h03
`define XDT_CLK_AI16    8'h04
`define XDT_CLK_IMM_R   8'h04
`define XDT_CLK_IMM_M   8'h10
`define XDT_CLK_RR      8'h03
`define XDT_CLK_RM      8'h0a
`define XDT_CLK_NARROW  8'h04
`define XDT_CLK_SWP_R   8'h04
`define XDT_CLK_SWP_M   8'h11
`define XDT_CLK_SWPAX   8'h03
`define XDT_CLK_SCAN    8'h0f
`define XDT_CLK_SCAN_N  8'h13
`define XDT_CLK_STORE   8'h0a
`define XDT_CLK_FLAG    8'h02
`define XDT_CLK_XLT     8'h0b
`define XDT_CLK_XLT_N   8'h0f

`endif

// ### tb/testbench.sv
// Bench for the tail decoder: byte stream, register port, record checks.
// Assumes xdt_decoder and xdt_monitor are compiled first.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0, srst = 1'b1, byte_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  byte_data = 8'h0, al_val = 8'h0, reg_addr = 8'h0, dec_clk_q;
  logic [15:0] bx_val = 16'h0, bp_val = 16'h0, si_val = 16'h0, di_val = 16'h0, ea;
  logic [15:0] dec_disp_q, dec_imm_q, dec_ea_q, dec_step_q;
  logic [31:0] reg_wdata = 32'h0, seed = 32'h4f, r, reg_rdata_q;
  logic [8:0]  flag_res_q, flag_clr_q, flag_set_q, flag_undef_q;
  logic [3:0]  dec_op_q;
  logic [2:0]  dec_aux_q, dec_reg_q, dec_rm_q;
  logic [1:0]  dec_mode_q, dec_seg_q, sr, m;
  logic        byte_ready_q, dec_valid_q, dec_word_q, dec_ext_q, dec_mem_q, dec_wb_q, dr;
  logic        dec_clk_n_q, dec_illegal_q, irq_en_q, dir_q;
  int          num_errors = 0, n_compared = 0;
  xdt_decoder dut_u (
    .sys_clk(sys_clk), .srst(srst), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready_q(byte_ready_q), .bx_val(bx_val), .bp_val(bp_val), .si_val(si_val),
    .di_val(di_val), .al_val(al_val), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .dec_valid_q(dec_valid_q),
    .dec_op_q(dec_op_q), .dec_word_q(dec_word_q), .dec_mode_q(dec_mode_q),
    .dec_aux_q(dec_aux_q), .dec_ext_q(dec_ext_q), .dec_reg_q(dec_reg_q), .dec_rm_q(dec_rm_q),
    .dec_mem_q(dec_mem_q), .dec_disp_q(dec_disp_q), .dec_imm_q(dec_imm_q),
    .dec_ea_q(dec_ea_q), .dec_seg_q(dec_seg_q), .dec_step_q(dec_step_q), .dec_wb_q(dec_wb_q),
    .dec_clk_q(dec_clk_q), .dec_clk_n_q(dec_clk_n_q), .flag_res_q(flag_res_q),
    .flag_clr_q(flag_clr_q), .flag_set_q(flag_set_q), .flag_undef_q(flag_undef_q),
    .dec_illegal_q(dec_illegal_q), .irq_en_q(irq_en_q), .dir_q(dir_q));
  // Clock
  initial forever #5 sys_clk = ~sys_clk;
  // Xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) num_errors++;
    if (s !== e) $display("BAD %s expected %h seen %h", nm, e, s);
  endtask
  // Offer one byte until taken
  task put(input logic [7:0] b);
    byte_valid <= 1'b1;
    byte_data <= b;
    do @(posedge sys_clk); while (byte_ready_q !== 1'b1);
  endtask
  // Record stands two edges after the last byte
  task fin();
    byte_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("valid", 1, dec_valid_q);
  endtask
  task ins(input logic [23:0] b, input int n, input logic [3:0] op, input logic [7:0] ck);
    for (int i = 0; i < n; i++) put(b[23 - 8 * i -: 8]);
    fin();
    chk("op", op, dec_op_q);
    chk("clk", ck, dec_clk_q);
  endtask
  // Register port cycle; read data one cycle later
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    if (!w) chk("rdata", d, reg_rdata_q);
  endtask
  task print_verdict();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    {bx_val, bp_val, si_val, di_val} <= {xs(), xs()};
    al_val <= seed[7:0];
    repeat (2) @(posedge sys_clk);
    ins(24'hf90000, 1, 4'h6, 8'h02);
    ins(24'hfb0000, 1, 4'h8, 8'h02);
    chk("irq", 0, irq_en_q);
    ins(24'haa0000, 1, 4'h9, 8'h0a);
    chk("irq", 1, irq_en_q);
    chk("step", 1, dec_step_q);
    ins(24'hd70000, 1, 4'hc, 8'h0b);
    ea = bx_val + al_val;
    chk("table ea", {ea, 16'h3}, {dec_ea_q, 14'h0, dec_seg_q});
    ins(24'h930000, 1, 4'hb, 8'h03);
    chk("word reg", 4'hb, {dec_word_q, dec_reg_q});
    ins(24'h87c800, 2, 4'hb, 8'h04);
    ins(24'h2d3412, 3, 4'h4, 8'h04);
    chk("imm", 16'h1234, dec_imm_q);
    chk("sub flags", 9'h11f, flag_res_q);
    ins(24'h83d880, 3, 4'h3, 8'h04);
    chk("imm", 16'hff80, dec_imm_q);
    ins(24'hd1f800, 2, 4'h1, 8'h02);
    chk("ext", 1, dec_ext_q);
    ins(24'hc0e803, 3, 4'h2, 8'h05);
    chk("shr flags", {9'h01a, 9'h001, 9'h104}, {flag_res_q, flag_clr_q, flag_undef_q});
    chk("count n", 1, dec_clk_n_q);
    ins(24'hf6c005, 3, 4'ha, 8'h04);
    ins(24'h340100, 2, 4'hd, 8'h03);
    // Random operand bytes through the word exclusive-or, register and memory forms
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      m = r[7:6];
      dr = m == 2'h2 || m == 2'h0 && r[2:0] == 3'h6;
      if (r[13]) put({3'h1, r[12:11], 3'h6});
      put(8'h33);
      put(r[7:0]);
      if (m == 2'h1 || dr) put(r[23:16]);
      if (dr) put(r[31:24]);
      fin();
      chk("modrm", r[7:0], {dec_mode_q, dec_aux_q, dec_rm_q});
      chk("reg", r[5:3], dec_reg_q);
      chk("mem ext", {m != 2'h3, 1'b0}, {dec_mem_q, dec_ext_q});
      ea = r[2:1] == 2'h3 ? (r[0] ? bx_val : m == 2'h0 ? 16'h0 : bp_val)
         : r[2] ? (r[0] ? di_val : si_val) : (r[1] ? bp_val : bx_val) + (r[0] ? di_val : si_val);
      ea = ea + (dr ? r[31:16] : m == 2'h1 ? {{8{r[23]}}, r[23:16]} : 16'h0);
      sr = r[13] ? r[12:11] : r[2:1] == 2'h1 || r[2:0] == 3'h6 && m != 2'h0 ? 2'h2 : 2'h3;
      if (m != 2'h3) chk("ea", {ea, 14'h0, sr}, {dec_ea_q, 14'h0, dec_seg_q});
      chk("clk", m == 2'h3 ? 8'h03 : 8'h0a, dec_clk_q);
    end
    acc(1'b1, 8'h00, 32'h3);
    ins(24'hfd0000, 1, 4'h7, 8'h02);
    chk("dir ill", 2'h2, {dir_q, dec_illegal_q});
    ins(24'hae0000, 1, 4'h5, 8'h13);
    chk("scan", {di_val, 16'hffff}, {dec_ea_q, dec_step_q});
    chk("scan seg", 0, dec_seg_q);
    acc(1'b0, 8'h00, 32'h3);
    acc(1'b0, 8'h04, 32'h3);
    acc(1'b0, 8'h20, 32'h0);
    print_verdict();
  end
endmodule // testbench
bind xdt_decoder xdt_monitor mon_u (
  .sys_clk(sys_clk), .srst(srst), .dec_valid_q(dec_valid_q), .dec_op_q(dec_op_q),
  .dec_mode_q(dec_mode_q), .dec_rm_q(dec_rm_q), .dec_disp_q(dec_disp_q),
  .dec_clk_q(dec_clk_q), .dec_wb_q(dec_wb_q), .flag_clr_q(flag_clr_q), .flag_set_q(flag_set_q));

// ### tb/xdt_decoder_monitor.sv
// Checker for decoded records: displacement, flag masks, clock counts.
// Assumes a bind onto xdt_decoder; one clock, sync reset.
`timescale 1ns/1ps
module xdt_monitor (
  input wire        sys_clk,
  input wire        srst,
  input wire        dec_valid_q,
  input wire [3:0]  dec_op_q,
  input wire [1:0]  dec_mode_q,
  input wire [2:0]  dec_rm_q,
  input wire [15:0] dec_disp_q,
  input wire [7:0]  dec_clk_q,
  input wire        dec_wb_q,
  input wire [8:0]  flag_clr_q,
  input wire [8:0]  flag_set_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire v = dec_valid_q; // Record strobe
  // ----------------
  // Record checks
  // ----------------
  sext_a: assert property (v && dec_mode_q == 2'h1 |->
    dec_disp_q[15:8] == {8{dec_disp_q[7]}}) else $error("disp not extended");
  no_disp_a: assert property (v && dec_mode_q == 2'h0 && dec_rm_q != 3'h6 |->
    dec_disp_q == 16'h0) else $error("stray disp");
  shift_clk_a: assert property (v && dec_op_q == 4'h1 && dec_mode_q == 2'h3 |->
    dec_clk_q inside {8'h02, 8'h05}) else $error("shift clocks");
  swap_clk_a: assert property (v && dec_op_q == 4'hb && dec_mode_q == 2'h3 |->
    dec_clk_q inside {8'h03, 8'h04}) else $error("swap clocks");
  xor_flag_a: assert property (v && dec_op_q == 4'hd |->
    flag_clr_q[8] && flag_clr_q[0]) else $error("xor flags");
  test_wb_a: assert property (v && dec_op_q == 4'ha |->
    !dec_wb_q && flag_clr_q[8]) else $error("and compare wrote back");
  store_flag_a: assert property (v && dec_op_q == 4'h9 |->
    (flag_clr_q | flag_set_q) == 9'h0) else $error("store flags");
  carry_clk_a: assert property (v && dec_op_q == 4'h6 |->
    dec_clk_q == 8'h02 && flag_set_q[0]) else $error("set carry");
  cover property (v && dec_mode_q == 2'h1);
  cover property (v && dec_op_q == 4'hb);
  cover property (v && dec_op_q == 4'h2);
endmodule // xdt_monitor
